// ==== hw/quad_pwm_command_block.sv ====
// Behaviour
// - four independent channels, counters loaded from one shared 24-bit load register
// - each channel has a 24-bit period down-counter and a duty down-counter
// - start loads both counters and drives output active when enabled
// - duty counter halts at zero, output goes inactive for rest of period
// - period counter at one (or zero) reloads both counters instead of stepping down, new cycle starts
// - duty initial value zero keeps the output inactive
// - equal duty and period values give continuous active output, no glitch
// - command byte holds opcode, channel selector and one argument bit
// - reset clears every register and setting to zero, except pwm outputs and pin oe_n, which are set to all ones
// - stop halts the selected channel or all channels per argument bit
// - load copies load register into period or duty initial value
// - opcode 0010 sets polarity from argument; pulse sits at period start
// - opcode 0011 enables or disables pulse output per argument bit
// - opcode 0100 clears selected channel or all channels per argument
// - opcode 0101 enables or disables routing onto port C pins
// - opcode 0110 selects one clock source shared by both counters of channel
// - opcode 0111 starts selected channel or all channels per argument
// - disabled output held at inverse of polarity while counters may run
// - routing forces the four port C pins to output, overriding direction bits
// - converter clock or trigger request wins over modulator on shared pin
// - routing off returns pins to their own direction and stored output value
`timescale 1ns/1ps
`default_nettype none

module quad_pwm_command_block (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst,
  input  wire logic [pwm_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [pwm_pkg::CNT_W-1:0]     i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [pwm_pkg::CNT_W-1:0]     o_rdata,
  input  wire logic [pwm_pkg::NUM_CH-1:0]    i_alt_tick,
  input  wire pwm_pkg::dio_in_s              i_dio,
  output logic      [pwm_pkg::NUM_CH-1:0]    o_pwm,
  output pwm_pkg::pin_s                      o_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pwm_pkg::state_s state_reg;
  pwm_pkg::state_s state_next;

  // ----------------------------------------------------------------
  // channel selector decode
  // ----------------------------------------------------------------
  function automatic logic [pwm_pkg::NUM_CH-1:0] select_mask(
    input logic [2:0] sel
  );
    logic [pwm_pkg::NUM_CH-1:0] mask;
    mask = '0;
    for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
      if ({1'b0, sel} == 4'(i)) begin
        mask[i] = 1'b1;
      end
    end
    return mask;
  endfunction : select_mask

  // ----------------------------------------------------------------
  // counter clock source
  // ----------------------------------------------------------------
  function automatic logic tick_of(
    input pwm_pkg::channel_s ch,
    input logic              alt_tick
  );
    logic tick;
    tick = 1'b1;
    if (ch.clk_sel) begin
      tick = alt_tick;
    end
    return tick;
  endfunction : tick_of

  // ----------------------------------------------------------------
  // one counter step
  // ----------------------------------------------------------------
  function automatic pwm_pkg::channel_s count_step(
    input pwm_pkg::channel_s ch,
    input logic              tick
  );
    pwm_pkg::channel_s nxt;
    nxt = ch;
    if (ch.run == pwm_pkg::CH_RUN && tick) begin
      if (ch.period_cnt <= pwm_pkg::CNT_ONE) begin
        nxt.period_cnt = ch.init_period;
        nxt.duty_cnt   = ch.init_duty;
      end else begin
        nxt.period_cnt = ch.period_cnt - pwm_pkg::CNT_ONE;
        if (ch.duty_cnt != '0) begin
          nxt.duty_cnt = ch.duty_cnt - pwm_pkg::CNT_ONE;
        end
      end
    end
    return nxt;
  endfunction : count_step

  // ----------------------------------------------------------------
  // per-channel status nibble
  // ----------------------------------------------------------------
  function automatic logic [pwm_pkg::STAT_CH_W-1:0] channel_status(
    input pwm_pkg::channel_s ch
  );
    logic [pwm_pkg::STAT_CH_W-1:0] bits;
    bits                         = '0;
    bits[pwm_pkg::STAT_RUN_BIT]  = ch.run == pwm_pkg::CH_RUN;
    bits[pwm_pkg::STAT_OEN_BIT]  = ch.out_en;
    bits[pwm_pkg::STAT_POL_BIT]  = ch.polarity;
    bits[pwm_pkg::STAT_CSEL_BIT] = ch.clk_sel;
    return bits;
  endfunction : channel_status

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  function automatic logic [pwm_pkg::CNT_W-1:0] status_word(
    input pwm_pkg::state_s s
  );
    logic [pwm_pkg::CNT_W-1:0] word;
    word = '0;
    for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
      word[i*pwm_pkg::STAT_CH_W +: pwm_pkg::STAT_CH_W] = channel_status(s.ch[i]);
    end
    word[pwm_pkg::STAT_ROUTE_BIT] = s.route_en;
    return word;
  endfunction : status_word

  // ----------------------------------------------------------------
  // counter view of last named channel
  // ----------------------------------------------------------------
  function automatic logic [pwm_pkg::CNT_W-1:0] view_count(
    input pwm_pkg::state_s s,
    input logic            duty
  );
    logic [pwm_pkg::CNT_W-1:0] word;
    word = '0;
    if (s.view_sel[2] == 1'b0) begin
      if (duty) begin
        word = s.ch[s.view_sel[1:0]].duty_cnt;
      end else begin
        word = s.ch[s.view_sel[1:0]].period_cnt;
      end
    end
    return word;
  endfunction : view_count

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [pwm_pkg::CNT_W-1:0] read_word(
    input pwm_pkg::state_s            s,
    input logic [pwm_pkg::ADDR_W-1:0] addr
  );
    logic [pwm_pkg::CNT_W-1:0] word;
    word = '0;
    if (addr == pwm_pkg::OFS_LOAD) begin
      word = s.load_value;
    end else if (addr == pwm_pkg::OFS_STATUS) begin
      word = status_word(s);
    end else if (addr == pwm_pkg::OFS_PERIOD_CNT) begin
      word = view_count(s, 1'b0);
    end else if (addr == pwm_pkg::OFS_DUTY_CNT) begin
      word = view_count(s, 1'b1);
    end else begin
      word = '0;
    end
    return word;
  endfunction : read_word

  // ----------------------------------------------------------------
  // command on one channel
  // ----------------------------------------------------------------
  function automatic pwm_pkg::channel_s apply_cmd(
    input pwm_pkg::channel_s         ch,
    input pwm_pkg::cmd_s             cmd,
    input logic                      hit_one,
    input logic                      hit_any,
    input logic [pwm_pkg::CNT_W-1:0] load_value
  );
    pwm_pkg::channel_s nxt;
    nxt = ch;
    case (cmd.op)
      pwm_pkg::OP_STOP: begin
        if (hit_any) begin
          nxt.run = pwm_pkg::CH_IDLE;
        end
      end
      pwm_pkg::OP_LOAD: begin
        if (hit_one && !cmd.arg) begin
          nxt.init_period = load_value;
        end else if (hit_one) begin
          nxt.init_duty = load_value;
        end
      end
      pwm_pkg::OP_POLARITY: begin
        if (hit_one) begin
          nxt.polarity = cmd.arg;
        end
      end
      pwm_pkg::OP_OUT_EN: begin
        if (hit_one) begin
          nxt.out_en = cmd.arg;
        end
      end
      pwm_pkg::OP_CLEAR: begin
        if (hit_any) begin
          nxt = '0;
        end
      end
      pwm_pkg::OP_CLK_SEL: begin
        if (hit_one) begin
          nxt.clk_sel = cmd.arg;
        end
      end
      pwm_pkg::OP_START: begin
        if (hit_any) begin
          nxt.run        = pwm_pkg::CH_RUN;
          nxt.period_cnt = ch.init_period;
          nxt.duty_cnt   = ch.init_duty;
        end
      end
      default: begin
      end
    endcase
    return nxt;
  endfunction : apply_cmd

  // ----------------------------------------------------------------
  // channel output level
  // ----------------------------------------------------------------
  function automatic logic drive_level(
    input pwm_pkg::channel_s ch
  );
    logic active;
    logic level;
    active = ch.run == pwm_pkg::CH_RUN && ch.duty_cnt != '0;
    if (ch.out_en && active) begin
      level = ch.polarity;
    end else begin
      level = ~ch.polarity;
    end
    return level;
  endfunction : drive_level

  // ----------------------------------------------------------------
  // port c pin drive
  // ----------------------------------------------------------------
  function automatic pwm_pkg::pin_s pin_drive(
    input logic [pwm_pkg::NUM_CH-1:0] pwm,
    input logic                       route_en,
    input pwm_pkg::dio_in_s           dio
  );
    pwm_pkg::pin_s pin;
    pin = '0;
    for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
      if (dio.conv_req[i]) begin
        pin.out[i]  = 1'b0;
        pin.oe_n[i] = 1'b1;
      end else if (route_en) begin
        pin.out[i]  = pwm[i];
        pin.oe_n[i] = 1'b0;
      end else begin
        pin.out[i]  = dio.out_val[i];
        pin.oe_n[i] = ~dio.dir[i];
      end
    end
    return pin;
  endfunction : pin_drive

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pwm_pkg::cmd_s              cmd;
    logic [pwm_pkg::NUM_CH-1:0] tick;
    logic [pwm_pkg::NUM_CH-1:0] hit_one;
    logic [pwm_pkg::NUM_CH-1:0] hit_any;
    cmd              = pwm_pkg::cmd_s'(i_wdata[7:0]);
    tick             = '0;
    hit_one          = '0;
    hit_any          = '0;
    state_next       = state_reg;
    state_next.rdata = '0;

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
      tick[i]          = tick_of(state_reg.ch[i], i_alt_tick[i]);
      state_next.ch[i] = count_step(state_reg.ch[i], tick[i]);
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (i_rd) begin
      state_next.rdata = read_word(state_reg, i_addr);
    end

    // ----------------------------------------------------------------
    // register writes and commands
    // ----------------------------------------------------------------
    if (i_wr) begin
      if (i_addr == pwm_pkg::OFS_LOAD) begin
        state_next.load_value = i_wdata;
      end else if (i_addr == pwm_pkg::OFS_CMD) begin
        state_next.view_sel = cmd.sel;
        hit_one             = select_mask(cmd.sel);
        hit_any             = hit_one | {pwm_pkg::NUM_CH{cmd.arg}};
        if (cmd.op == pwm_pkg::OP_ROUTE) begin
          state_next.route_en = cmd.arg;
        end
        for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
          state_next.ch[i] = apply_cmd(state_next.ch[i], cmd, hit_one[i], hit_any[i],
                                       state_reg.load_value);
        end
      end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
      state_next.pwm[i] = drive_level(state_next.ch[i]);
    end
    state_next.pin = pin_drive(state_next.pwm, state_next.route_en, i_dio);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg            <= '0;
      state_reg.load_value <= pwm_pkg::LOAD_RST;
      state_reg.pwm        <= pwm_pkg::PWM_RST;
      state_reg.pin.oe_n   <= pwm_pkg::PIN_OE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_pwm   = state_reg.pwm;
  assign o_pin   = state_reg.pin;

endmodule : quad_pwm_command_block

`default_nettype wire

// ==== hw/pwm_pkg.sv ====
package pwm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CNT_W  = 24;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LOAD       = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CMD        = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_CNT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DUTY_CNT   = 4'h4;

  // ----------------------------------------------------------------
  // status field layout
  // ----------------------------------------------------------------
  localparam int unsigned STAT_CH_W     = 4;
  localparam int unsigned STAT_RUN_BIT  = 0;
  localparam int unsigned STAT_OEN_BIT  = 1;
  localparam int unsigned STAT_POL_BIT  = 2;
  localparam int unsigned STAT_CSEL_BIT = 3;
  localparam int unsigned STAT_ROUTE_BIT = 16;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_STOP     = 4'h0;
  localparam logic [3:0] OP_LOAD     = 4'h1;
  localparam logic [3:0] OP_POLARITY = 4'h2;
  localparam logic [3:0] OP_OUT_EN   = 4'h3;
  localparam logic [3:0] OP_CLEAR    = 4'h4;
  localparam logic [3:0] OP_ROUTE    = 4'h5;
  localparam logic [3:0] OP_CLK_SEL  = 4'h6;
  localparam logic [3:0] OP_START    = 4'h7;

  // ----------------------------------------------------------------
  // reset values and counter step constant
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  LOAD_RST   = 24'h000000;
  localparam logic [NUM_CH-1:0] PWM_RST    = 4'hf;
  localparam logic [NUM_CH-1:0] PIN_OE_RST = 4'hf;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 24'h000001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RUN  = 1'b1
  } run_e;

  typedef struct packed {
    logic [3:0] op;
    logic [2:0] sel;
    logic       arg;
  } cmd_s;

  typedef struct packed {
    run_e             run;
    logic             out_en;
    logic             polarity;
    logic             clk_sel;
    logic [CNT_W-1:0] init_period;
    logic [CNT_W-1:0] init_duty;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] duty_cnt;
  } channel_s;

  typedef struct packed {
    logic [NUM_CH-1:0] dir;
    logic [NUM_CH-1:0] out_val;
    logic [NUM_CH-1:0] conv_req;
  } dio_in_s;

  typedef struct packed {
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] oe_n;
  } pin_s;

  typedef struct packed {
    channel_s [NUM_CH-1:0] ch;
    logic                  route_en;
    logic [2:0]            view_sel;
    logic [CNT_W-1:0]      load_value;
    logic [CNT_W-1:0]      rdata;
    logic [NUM_CH-1:0]     pwm;
    pin_s                  pin;
  } state_s;

endpackage : pwm_pkg

// ==== tb/quad_pwm_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module quad_pwm_props (
  input wire logic                       i_clock,
  input wire logic                       i_rst,
  input wire logic [pwm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pwm_pkg::CNT_W-1:0]  i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [pwm_pkg::CNT_W-1:0]  o_rdata,
  input wire logic [pwm_pkg::NUM_CH-1:0] i_alt_tick,
  input wire pwm_pkg::dio_in_s           i_dio,
  input wire logic [pwm_pkg::NUM_CH-1:0] o_pwm,
  input wire pwm_pkg::pin_s              o_pin
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic is_cmd;
  assign is_cmd = i_wr && i_addr == pwm_pkg::OFS_CMD;
  a_reset_state: assert property ($past(i_rst) |-> o_pwm == 4'hf && o_pin.oe_n == 4'hf && o_rdata == 24'h0)
    else $error("outputs wrong after reset");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 24'h0)
    else $error("read data outside read slot");
  a_load_readback: assert property ($past(i_wr && i_addr == pwm_pkg::OFS_LOAD, 2)
    && $past(i_rd && i_addr == pwm_pkg::OFS_LOAD) |-> o_rdata == $past(i_wdata, 2)) else $error("load readback wrong");
  a_no_readback: assert property ($past(i_rd) && ($past(i_addr) == pwm_pkg::OFS_CMD || $past(i_addr) > 4'h4)
    |-> o_rdata == 24'h0) else $error("write-only or unmapped read not zero");
  a_conv_wins: assert property ($past(i_dio.conv_req) != 4'h0 |->
    (o_pin.oe_n & $past(i_dio.conv_req)) == $past(i_dio.conv_req) && (o_pin.out & $past(i_dio.conv_req)) == 4'h0)
    else $error("converter pin not released");
  a_stop_hold: assert property ($past(is_cmd && i_wdata[7:0] == 8'h01) && !i_wr |=> $stable(o_pwm))
    else $error("output moves after stop all");
  a_clear_all: assert property ($past(is_cmd && i_wdata[7:0] == 8'h41) && !i_wr |=> o_pwm == 4'hf)
    else $error("clear all left output active");
  a_route_force: assert property ($past(is_cmd && i_wdata[7:0] == 8'h51) && !i_wr
    |=> o_pin.oe_n == $past(i_dio.conv_req)) else $error("routed pins not driven");
endmodule : quad_pwm_props
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                       i_clock;
  logic                       i_rst;
  logic [pwm_pkg::ADDR_W-1:0] i_addr;
  logic [pwm_pkg::CNT_W-1:0]  i_wdata;
  logic                       i_wr;
  logic                       i_rd;
  logic [pwm_pkg::CNT_W-1:0]  o_rdata;
  logic [pwm_pkg::NUM_CH-1:0] i_alt_tick;
  pwm_pkg::dio_in_s           i_dio;
  logic [pwm_pkg::NUM_CH-1:0] o_pwm;
  pwm_pkg::pin_s              o_pin;
  int                         errors;
  int                         compares;
  quad_pwm_command_block dut_u (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
                                .i_alt_tick, .i_dio, .o_pwm, .o_pin);
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic cmd(input logic [7:0] c);
    wr(pwm_pkg::OFS_CMD, {16'h0, c});
  endtask : cmd
  task automatic rd(input logic [3:0] a, input logic [23:0] m, input logic [23:0] exp, input string name);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    check(name, o_rdata & m, exp);
  endtask : rd
  task automatic count_ones(input int ch, input int n, output int ones);
    ones = 0;
    #1;
    for (int k = 0; k < n; k++) begin
      ones += int'(o_pwm[ch]);
      @(posedge i_clock);
      #1;
    end
  endtask : count_ones
  task automatic run_ch(input int ch, input int p, input int d, input logic alt, input int exp);
    logic [7:0]  s;
    logic [23:0] m;
    int          ones;
    s = {4'h0, ch[2:0], 1'b0};
    m = 24'hf << (4 * ch);
    wr(pwm_pkg::OFS_LOAD, 24'(p));
    cmd(s | 8'h10);
    wr(pwm_pkg::OFS_LOAD, 24'(d));
    cmd(s | 8'h11);
    cmd(s | 8'h21);
    cmd(s | 8'h31);
    cmd(s | 8'h60 | {7'h0, alt});
    cmd(s | 8'h70);
    count_ones(ch, 2 * p, ones);
    check("active cycles", 24'(ones), 24'(exp));
    rd(pwm_pkg::OFS_STATUS, m, 24'({alt, 3'b111}) << (4 * ch), "status run");
    if (alt) rd(pwm_pkg::OFS_PERIOD_CNT, 24'hffffff, 24'(p), "held count");
    cmd(s | 8'h30);
    count_ones(ch, 2 * p, ones);
    check("disabled output", 24'(ones), 24'h0);
    cmd(s);
    rd(pwm_pkg::OFS_STATUS, m, 24'({alt, 3'b100}) << (4 * ch), "status stop");
  endtask : run_ch
  task automatic pins(input logic [3:0] oe, input logic [3:0] out);
    repeat (2) @(posedge i_clock);
    #1;
    check("pin oe", 24'(o_pin.oe_n), 24'(oe));
    check("pin out", 24'(o_pin.out), 24'(out));
  endtask : pins
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    i_rst      = 1'b1;
    i_addr     = '0;
    i_wdata    = '0;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    i_alt_tick = '0;
    i_dio      = '0;
    errors     = 0;
    compares   = 0;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    check("reset pwm", 24'(o_pwm), 24'hf);
    rd(pwm_pkg::OFS_LOAD, 24'hffffff, 24'h0, "reset load");
    rd(pwm_pkg::OFS_STATUS, 24'hffffff, 24'h0, "reset status");
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= pwm_pkg::OFS_LOAD;
    i_wdata <= 24'h5a3c96;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_clock);
    i_rd    <= 1'b0;
    #1;
    check("load readback", o_rdata, 24'h5a3c96);
    $display("reset test done");
    run_ch(0, 5, 2, 1'b0, 4);
    run_ch(1, 4, 0, 1'b0, 0);
    run_ch(2, 3, 3, 1'b0, 6);
    run_ch(3, 4, 2, 1'b1, 8);
    $display("channel test done");
    cmd(8'h71);
    rd(pwm_pkg::OFS_STATUS, 24'h1111, 24'h1111, "start all");
    cmd(8'h01);
    rd(pwm_pkg::OFS_STATUS, 24'h1111, 24'h0, "stop all");
    cmd(8'h41);
    rd(pwm_pkg::OFS_STATUS, 24'hffffff, 24'h0, "clear all");
    check("cleared pwm", 24'(o_pwm), 24'hf);
    rd(pwm_pkg::OFS_CMD, 24'hffffff, 24'h0, "command read");
    rd(4'hf, 24'hffffff, 24'h0, "unmapped read");
    $display("command test done");
    i_dio <= '{dir: 4'h5, out_val: 4'ha, conv_req: 4'h0};
    pins(4'ha, 4'ha);
    cmd(8'h51);
    pins(4'h0, 4'hf);
    rd(pwm_pkg::OFS_STATUS, 24'h10000, 24'h10000, "route status");
    i_dio <= '{dir: 4'h5, out_val: 4'ha, conv_req: 4'h2};
    pins(4'h2, 4'hd);
    cmd(8'h50);
    pins(4'ha, 4'h8);
    $display("pin test done");
    end_of_test();
  end
endmodule : tb
bind quad_pwm_command_block quad_pwm_props chk_u (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
                                                  .i_alt_tick, .i_dio, .o_pwm, .o_pin);
`default_nettype wire
